//--- src/acqt_pkg.sv
/*
 * Package for the acquisition timing and trigger controller: sizes, clock rates,
 * register map, field layouts, engine states and the AXI4-Lite carrier structs.
 * Assumes a single 50 MHz system clock and a 32-bit AXI4-Lite master.
 */
package acqt_pkg;
	localparam int ACQT_NENG = 3;
	localparam int ACQT_NCH = 6;
	localparam int ACQT_NBP = 8;
	localparam int ACQT_SW = 24;
	localparam int ACQT_CLK_HZ = 50_000_000;
	localparam int ACQT_CLK_PS = 1_000_000 / (ACQT_CLK_HZ / 1_000_000);
	localparam int ACQT_REF_HZ = 80_000_000;
	localparam int ACQT_BP_HZ = 100_000_000;
	localparam int ACQT_OSR = 8;
	// Oversample tick spacing in clk cycles (free running) or backplane ticks (locked).
	localparam int ACQT_FREE_DIV = ACQT_CLK_HZ / (ACQT_REF_HZ / ACQT_OSR);
	localparam int ACQT_LOCK_DIV = ACQT_BP_HZ / (ACQT_REF_HZ / ACQT_OSR);
	localparam int ACQT_HOLD_NS = 1000;
	localparam int ACQT_HOLD_CYC = (ACQT_HOLD_NS * 1000 + ACQT_CLK_PS - 1) / ACQT_CLK_PS;
	localparam logic [15:0] ACQT_GD_SMP = 16'h0010;
	localparam logic [3:0] ACQT_MIN_DIV = 4'h2;
	localparam logic [3:0] ACQT_SRC_FRONT = 4'h8;
	localparam logic [1:0] ACQT_AT_EDGE = 2'h0;
	localparam logic [1:0] ACQT_AT_HYST = 2'h1;
	localparam logic [1:0] ACQT_AT_WIN = 2'h2;
	localparam logic [7:0] ACQT_REG_CTRL = 8'h00;
	localparam logic [7:0] ACQT_REG_ATCFG = 8'h04;
	localparam logic [7:0] ACQT_REG_LEVEL = 8'h08;
	localparam logic [7:0] ACQT_REG_BAND = 8'h0C;
	localparam logic [7:0] ACQT_REG_STAT = 8'h10;
	localparam logic [7:0] ACQT_REG_TIDX = 8'h14;
	localparam logic [7:0] ACQT_REG_SIDX = 8'h18;
	localparam logic [7:0] ACQT_REG_ENG = 8'h20;
	localparam logic [7:0] ACQT_ENG_STEP = 8'h08;
	localparam logic [7:0] ACQT_ENG_CNT = 8'h04;
	localparam int ACQT_STAT_ERR = 16;
	localparam logic [1:0] ACQT_RESP_OK = 2'h0;
	localparam logic [1:0] ACQT_RESP_ERR = 2'h2;

	typedef enum logic [2:0] {ES_IDLE, ES_WAIT, ES_FILL, ES_PRE, ES_ARM, ES_POST, ES_RUN, ES_DONE} acqt_est_t;

	typedef struct packed {
		logic [9:0]  rsv2;
		logic [5:0]  mask;
		logic [3:0]  rsv1;
		logic [3:0]  div;
		logic [3:0]  src;
		logic        rsv0;
		logic        fall;
		logic        ref_en;
		logic        en;
	} acqt_ecfg_t;

	typedef struct packed {
		logic [7:0]  route;
		logic [6:0]  rsv;
		logic        lock;
	} acqt_ctrl_t;

	typedef struct packed {
		logic [7:0]  awaddr;
		logic        awvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        wvalid;
		logic        bready;
		logic [7:0]  araddr;
		logic        arvalid;
		logic        rready;
	} acqt_axi_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic [1:0]  bresp;
		logic        bvalid;
		logic        arready;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic        rvalid;
	} acqt_axi_rsp_t;
endpackage

//--- src/acqt_ctrl.sv
/*
 * Acquisition timing and trigger controller: oversample timebase, sync handling,
 * three timing engines with digital start and analog reference triggering, and
 * an AXI4-Lite register slave.
 * Assumes all inputs are synchronous to clk; the backplane reference arrives as
 * a one-cycle tick per 100 MHz period group and converter data is valid on
 * each oversample tick.
 */
module acqt_ctrl (
	// Clock and reset
	input  wire logic                   clk,
	input  wire logic                   sys_rst,
	// Register bus
	input  wire acqt_pkg::acqt_axi_req_t s_axi_req,
	output      acqt_pkg::acqt_axi_rsp_t s_axi_rsp,
	// Timebase and converters
	input  wire logic                   backplane_reference_100mhz,
	input  wire logic                   sync_pulse_in,
	input  wire logic [5:0][23:0]       adc_data,
	output      logic                   adc_conv_en,
	output      logic                   adc_reset,
	// Triggers
	input  wire logic [7:0]             trig_in,
	input  wire logic                   front_programmable_input,
	output      logic [7:0]             trig_out,
	output      logic [7:0]             trig_oe,
	// Engine sample strobes
	output      logic [2:0]             eng_strobe
);
	import acqt_pkg::*;

	function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
		begin
			if (s[b])
				r[8*b +: 8] = nw[8*b +: 8];
		end
		return r;
	endfunction

	acqt_axi_rsp_t rsp_q, rsp_d;
	acqt_ctrl_t    ctrl_q, ctrl_d;
	acqt_ecfg_t    cfg_q [ACQT_NENG];
	acqt_ecfg_t    cfg_d [ACQT_NENG];
	logic [31:0]   ecnt_q [ACQT_NENG];
	logic [31:0]   ecnt_d [ACQT_NENG];
	logic [7:0]    atcfg_q, atcfg_d;
	logic [23:0]   level_q, level_d, band_q, band_d;
	logic          err_q, err_d;
	logic [31:0]   tidx_q, tidx_d, sidx_q, sidx_d;
	acqt_est_t     est_q [ACQT_NENG];
	acqt_est_t     est_d [ACQT_NENG];

	// A channel mask may only be enabled if no other live engine owns any of its channels.
	function automatic logic [5:0] claimed(input int excl);
		logic [5:0] m;
		m = 6'h00;
		for (int e = 0; e < ACQT_NENG; e++)
		begin
			if (e != excl && cfg_q[e].en)
				m = m | cfg_q[e].mask;
		end
		return m;
	endfunction

	always_comb
	begin
		logic [31:0] wv;
		logic [31:0] rd;
		logic        hit;
		wv = 32'h0;
		rd = 32'h0;
		hit = 1'b0;
		rsp_d = rsp_q;
		ctrl_d = ctrl_q;
		cfg_d = cfg_q;
		ecnt_d = ecnt_q;
		atcfg_d = atcfg_q;
		level_d = level_q;
		band_d = band_q;
		err_d = err_q;
		rsp_d.awready = 1'b0;
		rsp_d.wready = 1'b0;
		rsp_d.arready = 1'b0;
		if (rsp_q.bvalid && s_axi_req.bready)
			rsp_d.bvalid = 1'b0;
		if (rsp_q.rvalid && s_axi_req.rready)
			rsp_d.rvalid = 1'b0;
		if (!rsp_q.bvalid && !rsp_q.awready && s_axi_req.awvalid && s_axi_req.wvalid)
		begin
			rsp_d.awready = 1'b1;
			rsp_d.wready = 1'b1;
		end
		if (rsp_q.awready)
		begin
			rsp_d.bvalid = 1'b1;
			rsp_d.bresp = ACQT_RESP_OK;
			case (s_axi_req.awaddr)
				ACQT_REG_CTRL:
				begin
					wv = wmerge({16'h0, ctrl_q}, s_axi_req.wdata, s_axi_req.wstrb);
					ctrl_d = acqt_ctrl_t'(wv[15:0]);
					// Reserved bits always read back as zero, whatever software writes.
					ctrl_d.rsv = 7'h00;
				end
				ACQT_REG_ATCFG:
				begin
					wv = wmerge({24'h0, atcfg_q}, s_axi_req.wdata, s_axi_req.wstrb);
					atcfg_d = wv[7:0];
				end
				ACQT_REG_LEVEL:
				begin
					wv = wmerge({8'h0, level_q}, s_axi_req.wdata, s_axi_req.wstrb);
					level_d = wv[23:0];
				end
				ACQT_REG_BAND:
				begin
					wv = wmerge({8'h0, band_q}, s_axi_req.wdata, s_axi_req.wstrb);
					band_d = wv[23:0];
				end
				ACQT_REG_STAT:
				begin
					if (s_axi_req.wstrb[2] && s_axi_req.wdata[ACQT_STAT_ERR])
						err_d = 1'b0;
				end
				default:
				begin
					for (int e = 0; e < ACQT_NENG; e++)
					begin
						if (s_axi_req.awaddr == ACQT_REG_ENG + 8'(e) * ACQT_ENG_STEP)
						begin
							hit = 1'b1;
							wv = wmerge(cfg_q[e], s_axi_req.wdata, s_axi_req.wstrb);
							cfg_d[e] = acqt_ecfg_t'(wv & 32'h003F0FF7);
							if (cfg_d[e].en && (cfg_d[e].mask & claimed(e)) != 6'h00)
							begin
								cfg_d[e].en = 1'b0;
								err_d = 1'b1;
							end
						end
						if (s_axi_req.awaddr == ACQT_REG_ENG + 8'(e) * ACQT_ENG_STEP + ACQT_ENG_CNT)
						begin
							hit = 1'b1;
							ecnt_d[e] = wmerge(ecnt_q[e], s_axi_req.wdata, s_axi_req.wstrb);
						end
					end
					if (!hit)
						rsp_d.bresp = ACQT_RESP_ERR;
				end
			endcase
		end
		if (!rsp_q.rvalid && !rsp_q.arready && s_axi_req.arvalid)
			rsp_d.arready = 1'b1;
		if (rsp_q.arready)
		begin
			rsp_d.rvalid = 1'b1;
			rsp_d.rresp = ACQT_RESP_OK;
			case (s_axi_req.araddr)
				ACQT_REG_CTRL: rd = {16'h0, ctrl_q};
				ACQT_REG_ATCFG: rd = {24'h0, atcfg_q};
				ACQT_REG_LEVEL: rd = {8'h0, level_q};
				ACQT_REG_BAND: rd = {8'h0, band_q};
				ACQT_REG_STAT:
				begin
					for (int e = 0; e < ACQT_NENG; e++)
						rd[3*e +: 3] = est_q[e];
					rd[ACQT_STAT_ERR] = err_q;
				end
				ACQT_REG_TIDX: rd = tidx_q;
				ACQT_REG_SIDX: rd = sidx_q;
				default:
				begin
					rsp_d.rresp = ACQT_RESP_ERR;
					for (int e = 0; e < ACQT_NENG; e++)
					begin
						if (s_axi_req.araddr == ACQT_REG_ENG + 8'(e) * ACQT_ENG_STEP)
						begin
							rd = cfg_q[e];
							rsp_d.rresp = ACQT_RESP_OK;
						end
						if (s_axi_req.araddr == ACQT_REG_ENG + 8'(e) * ACQT_ENG_STEP + ACQT_ENG_CNT)
						begin
							rd = ecnt_q[e];
							rsp_d.rresp = ACQT_RESP_OK;
						end
					end
				end
			endcase
			rsp_d.rdata = rd;
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			rsp_q <= '0;
			ctrl_q <= '0;
			cfg_q <= '{default: '0};
			ecnt_q <= '{default: 32'h0};
			atcfg_q <= 8'h0;
			level_q <= 24'h0;
			band_q <= 24'h0;
			err_q <= 1'b0;
		end
		else
		begin
			rsp_q <= rsp_d;
			ctrl_q <= ctrl_d;
			cfg_q <= cfg_d;
			ecnt_q <= ecnt_d;
			atcfg_q <= atcfg_d;
			level_q <= level_d;
			band_q <= band_d;
			err_q <= err_d;
		end
	end
	assign s_axi_rsp = rsp_q;

	// Timebase. The converters only ever see this tick; there is no external clock path.
	logic [9:0] ts1_q, ts2_q, ts3_q;
	logic [3:0] osc_q, osc_d;
	logic [7:0] hold_q, hold_d;
	logic       conv_q, conv_d, arst_q, arst_d, sync_ev, ref_tick, conv_tick;

	always_comb
	begin
		sync_ev = ts2_q[9] && !ts3_q[9];
		ref_tick = ctrl_q.lock ? backplane_reference_100mhz : 1'b1;
		conv_tick = 1'b0;
		osc_d = osc_q;
		hold_d = (hold_q != 8'h0) ? hold_q - 8'h1 : hold_q;
		if (ref_tick)
		begin
			if (osc_q >= (ctrl_q.lock ? 4'(ACQT_LOCK_DIV - 1) : 4'(ACQT_FREE_DIV - 1)))
			begin
				osc_d = 4'h0;
				conv_tick = 1'b1;
			end
			else
				osc_d = osc_q + 4'h1;
		end
		conv_d = conv_tick;
		arst_d = sync_ev;
		if (sync_ev)
		begin
			osc_d = 4'h0;
			conv_d = 1'b0;
			hold_d = 8'(ACQT_HOLD_CYC);
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			ts1_q <= 10'h0;
			ts2_q <= 10'h0;
			ts3_q <= 10'h0;
			osc_q <= 4'h0;
			hold_q <= 8'h0;
			conv_q <= 1'b0;
			arst_q <= 1'b0;
		end
		else
		begin
			ts1_q <= {sync_pulse_in, front_programmable_input, trig_in};
			ts2_q <= ts1_q;
			ts3_q <= ts2_q;
			osc_q <= osc_d;
			hold_q <= hold_d;
			conv_q <= conv_d;
			arst_q <= arst_d;
		end
	end
	assign adc_conv_en = conv_q;
	assign adc_reset = arst_q;

	AST_ADC_RST: assert property (@(posedge clk) disable iff (sys_rst) sync_ev |=> adc_reset ##1 !adc_reset)
		else $error("sync did not pulse converter reset");
	AST_CONV_GAP: assert property (@(posedge clk) disable iff (sys_rst) adc_conv_en |=> !adc_conv_en [*4])
		else $error("oversample ticks closer than the divider allows");

	// Analog comparator; it only reads the channel data, so acquisition is untouched.
	logic        ast_q, ast_d, ahit_q, ahit_d;
	logic [2:0]  atch;
	logic [1:0]  amode;

	always_comb
	begin
		logic signed [23:0] cur;
		logic               above, inband;
		atch = atcfg_q[2:0];
		amode = atcfg_q[5:4];
		cur = (atch < 3'(ACQT_NCH)) ? $signed(adc_data[atch]) : $signed(24'h0);
		above = cur >= $signed(level_q);
		inband = above && cur <= $signed(band_q);
		ast_d = ast_q;
		ahit_d = 1'b0;
		if (conv_q && atch < 3'(ACQT_NCH))
		begin
			case (amode)
				ACQT_AT_EDGE:
				begin
					ahit_d = above && !ast_q;
					ast_d = above;
				end
				ACQT_AT_HYST:
				begin
					ahit_d = above && ast_q;
					if (ahit_d)
						ast_d = 1'b0;
					else if (cur < $signed(level_q) - $signed(band_q))
						ast_d = 1'b1;
				end
				ACQT_AT_WIN:
				begin
					ahit_d = inband && !ast_q;
					ast_d = inband;
				end
				default: ast_d = 1'b0;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			ast_q <= 1'b0;
			ahit_q <= 1'b0;
		end
		else
		begin
			ast_q <= ast_d;
			ahit_q <= ahit_d;
		end
	end

	// Timing engines. Every engine rate divides the same oversample tick.
	logic [3:0]  dv_q [ACQT_NENG];
	logic [3:0]  dv_d [ACQT_NENG];
	logic [15:0] cnt_q [ACQT_NENG];
	logic [15:0] cnt_d [ACQT_NENG];
	logic [2:0]  stb_q, stb_d, smp, dhit;
	logic [7:0]  tout_q, tout_d, toe_q, toe_d;

	always_comb
	begin
		logic [3:0] dvm;
		logic       sel, prv;
		dvm = 4'h0;
		sel = 1'b0;
		prv = 1'b0;
		est_d = est_q;
		dv_d = dv_q;
		cnt_d = cnt_q;
		stb_d = 3'h0;
		tout_d = 8'h0;
		toe_d = 8'h0;
		tidx_d = tidx_q;
		sidx_d = conv_q ? sidx_q + 32'h1 : sidx_q;
		smp = 3'h0;
		dhit = 3'h0;
		for (int e = 0; e < ACQT_NENG; e++)
		begin
			dvm = (cfg_q[e].div < ACQT_MIN_DIV) ? ACQT_MIN_DIV - 4'h1 : cfg_q[e].div - 4'h1;
			smp[e] = conv_q && dv_q[e] == dvm;
			if (conv_q)
				dv_d[e] = smp[e] ? 4'h0 : dv_q[e] + 4'h1;
			if (cfg_q[e].src < ACQT_SRC_FRONT + 4'h1)
			begin
				sel = ts2_q[cfg_q[e].src];
				prv = ts3_q[cfg_q[e].src];
			end
			else
			begin
				sel = 1'b0;
				prv = 1'b0;
			end
			dhit[e] = cfg_q[e].fall ? (prv && !sel) : (!prv && sel);
			case (est_q[e])
				ES_IDLE:
					if (cfg_q[e].en)
						est_d[e] = ES_WAIT;
				ES_WAIT:
					if (dhit[e] && hold_q == 8'h0)
					begin
						est_d[e] = ES_FILL;
						cnt_d[e] = 16'h0;
						dv_d[e] = 4'h0;
						tidx_d = sidx_q;
					end
				ES_FILL:
					if (smp[e])
					begin
						cnt_d[e] = cnt_q[e] + 16'h1;
						if (cnt_q[e] == ACQT_GD_SMP - 16'h1)
						begin
							est_d[e] = cfg_q[e].ref_en ? ES_PRE : ES_RUN;
							cnt_d[e] = 16'h0;
						end
					end
				ES_PRE:
					if (smp[e])
					begin
						stb_d[e] = 1'b1;
						cnt_d[e] = cnt_q[e] + 16'h1;
						if (cnt_q[e] + 16'h1 >= ecnt_q[e][15:0])
						begin
							est_d[e] = ES_ARM;
							cnt_d[e] = 16'h0;
						end
					end
				ES_ARM:
				begin
					stb_d[e] = smp[e];
					if (ahit_q && cfg_q[e].mask[atch])
					begin
						est_d[e] = ES_POST;
						tidx_d = sidx_q;
						tout_d = tout_d | ctrl_q.route;
						toe_d = toe_d | ctrl_q.route;
					end
				end
				ES_POST:
					if (smp[e])
					begin
						stb_d[e] = 1'b1;
						cnt_d[e] = cnt_q[e] + 16'h1;
						if (cnt_q[e] + 16'h1 >= ecnt_q[e][31:16])
							est_d[e] = ES_DONE;
					end
				ES_RUN: stb_d[e] = smp[e];
				ES_DONE: stb_d[e] = 1'b0;
				default: est_d[e] = ES_IDLE;
			endcase
			if (!cfg_q[e].en)
				est_d[e] = ES_IDLE;
			if (sync_ev)
				dv_d[e] = 4'h0;
		end
		if (sync_ev)
			sidx_d = 32'h0;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			est_q <= '{default: ES_IDLE};
			dv_q <= '{default: 4'h0};
			cnt_q <= '{default: 16'h0};
			stb_q <= 3'h0;
			tout_q <= 8'h0;
			toe_q <= 8'h0;
			tidx_q <= 32'h0;
			sidx_q <= 32'h0;
		end
		else
		begin
			est_q <= est_d;
			dv_q <= dv_d;
			cnt_q <= cnt_d;
			stb_q <= stb_d;
			tout_q <= tout_d;
			toe_q <= toe_d;
			tidx_q <= tidx_d;
			sidx_q <= sidx_d;
		end
	end
	assign eng_strobe = stb_q;
	assign trig_out = tout_q;
	assign trig_oe = toe_q;

	AST_HOLD_START: assert property (@(posedge clk) disable iff (sys_rst)
		hold_q != 8'h0 && est_q[0] == ES_WAIT |=> est_q[0] != ES_FILL)
		else $error("start taken inside the post-sync hold");
	AST_DIGITAL_START: assert property (@(posedge clk) disable iff (sys_rst)
		est_q[1] == ES_WAIT && est_d[1] == ES_FILL |-> dhit[1] && hold_q == 8'h0)
		else $error("start taken without a digital edge");
	AST_FILL_LEN: assert property (@(posedge clk) disable iff (sys_rst)
		est_q[0] == ES_FILL && est_d[0] != ES_FILL && cfg_q[0].en |-> smp[0] && cnt_q[0] == ACQT_GD_SMP - 16'h1)
		else $error("first sample before group delay");
	AST_ARM_AFTER_PRE: assert property (@(posedge clk) disable iff (sys_rst)
		est_q[2] == ES_ARM && $past(est_q[2]) != ES_ARM |-> $past(est_q[2]) == ES_PRE)
		else $error("armed without pre-trigger count");
	AST_REF_OUT: assert property (@(posedge clk) disable iff (sys_rst)
		est_q[0] == ES_ARM && est_d[0] == ES_POST |=> trig_out == ctrl_q.route && trig_oe == ctrl_q.route)
		else $error("reference event not routed");
	AST_CLAIM: assert property (@(posedge clk) disable iff (sys_rst)
		!(cfg_q[0].en && cfg_q[1].en) || (cfg_q[0].mask & cfg_q[1].mask) == 6'h00)
		else $error("channel owned by two engines");
	AST_RATE: assert property (@(posedge clk) disable iff (sys_rst) eng_strobe[0] |=> !eng_strobe[0] [*8])
		else $error("engine rate reached oversample rate");
endmodule

//--- sim/acqt_bp_model.sv
/*
 * Far-side model: backplane reference ticks, backplane trigger lines and the
 * front programmable input.
 * Assumes the bench calls its task from the main sequence on clk edges.
 */
module acqt_bp_model (
	// Clock
	input  wire logic       clk,
	// Far-side drive
	output      logic       ref_tick,
	output      logic [7:0] lines,
	output      logic       front
);
	timeunit 1ns;
	timeprecision 1ps;
	int gap = 2;
	int cnt = 0;

	// The backplane lines are pulled up, so a released line reads high.
	initial
	begin
		lines = 8'hFF;
		front = 1'b0;
		ref_tick = 1'b0;
	end

	// One shared tick stream feeds every module on the backplane.
	always @(posedge clk)
	begin
		cnt <= (cnt + 1 >= gap) ? 0 : cnt + 1;
		ref_tick <= (cnt + 1 >= gap);
	end

	// Index 8 is the front input; the level is held long enough to be seen.
	task drive_edge(input int idx, input logic rise);
		@(posedge clk);
		if (idx == 8) front <= !rise;
		else lines[idx] <= !rise;
		repeat (4) @(posedge clk);
		if (idx == 8) front <= rise;
		else lines[idx] <= rise;
	endtask
endmodule

//--- sim/tb_top.sv
/*
 * Self-checking bench for the acquisition timing and trigger controller.
 * Assumes the far-side model drives the triggers and the reference tick.
 */
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import acqt_pkg::*;
	logic             clk = 1'b0;
	logic             sys_rst = 1'b1;
	logic             sync_pulse_in = 1'b0;
	acqt_axi_req_t    req = '0;
	acqt_axi_rsp_t    rsp;
	logic [5:0][23:0] adc = '0;
	logic             conv;
	logic             arst;
	logic             rtick;
	logic             front;
	logic [7:0]       tin;
	logic [7:0]       tout;
	logic [7:0]       toe;
	logic [2:0]       stb;
	logic [31:0]      d;
	logic [1:0]       r;
	int               failures = 0;
	int               comparisons = 0;
	int               trig_cnt = 0;
	int               stb_cnt = 0;
	int               stb2_cnt = 0;
	int               n;
	int               s0;

	always #10 clk = ~clk;
	always @(posedge clk)
	begin
		trig_cnt <= trig_cnt + int'(tout != 8'h00);
		stb_cnt <= stb_cnt + int'(stb[0]);
		stb2_cnt <= stb2_cnt + int'(stb[2]);
	end

	acqt_ctrl DUT (.clk(clk), .sys_rst(sys_rst), .s_axi_req(req), .s_axi_rsp(rsp),
		.backplane_reference_100mhz(rtick), .sync_pulse_in(sync_pulse_in), .adc_data(adc),
		.adc_conv_en(conv), .adc_reset(arst), .trig_in(tin), .front_programmable_input(front),
		.trig_out(tout), .trig_oe(toe), .eng_strobe(stb));
	acqt_bp_model bp (.clk(clk), .ref_tick(rtick), .lines(tin), .front(front));

	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			failures++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		req.awaddr <= a;
		req.awvalid <= 1'b1;
		req.wdata <= v;
		req.wstrb <= 4'hF;
		req.wvalid <= 1'b1;
		req.bready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (rsp.awready) req.awvalid <= 1'b0;
			if (rsp.wready) req.wvalid <= 1'b0;
		end while (!rsp.bvalid);
		r = rsp.bresp;
		req.bready <= 1'b0;
	endtask

	task rd(input logic [7:0] a);
		@(posedge clk);
		req.araddr <= a;
		req.arvalid <= 1'b1;
		req.rready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (rsp.arready) req.arvalid <= 1'b0;
		end while (!rsp.rvalid);
		d = rsp.rdata;
		r = rsp.rresp;
		req.rready <= 1'b0;
	endtask

	// Polls the status word until engine e shows state v, or gives up.
	task wait_st(input int e, input int v);
		n = 0;
		do
		begin
			rd(ACQT_REG_STAT);
			n++;
		end while (int'(d[3*e+:3]) != v && n < 300);
		chk(32'(d[3*e+:3]), 32'(v));
	endtask

	// Measures the spacing of two oversample ticks in clk cycles.
	task gap();
		@(posedge clk iff conv);
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end while (!conv && n < 100);
	endtask

	task sync();
		@(posedge clk);
		sync_pulse_in <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end while (!arst && n < 8);
		chk(32'(arst), 32'h1);
		@(posedge clk);
		chk(32'(arst), 32'h0);
		sync_pulse_in <= 1'b0;
	endtask

	task t_regs();
		rd(ACQT_REG_CTRL);
		chk(d, 32'h0);
		rd(ACQT_REG_STAT);
		chk(d, 32'h0);
		rd(ACQT_REG_ENG);
		chk(d, 32'h0);
		rd(8'hFC);
		chk(32'(r), 32'(ACQT_RESP_ERR));
		chk(d, 32'h0);
		wr(8'hFC, 32'hFFFF_FFFF);
		chk(32'(r), 32'(ACQT_RESP_ERR));
		wr(ACQT_REG_CTRL, 32'h0000_00FE);
		rd(ACQT_REG_CTRL);
		chk(32'(r), 32'(ACQT_RESP_OK));
		chk(d, 32'h0);
		$display("regs done");
	endtask

	task t_tick();
		gap();
		chk(32'(n), 32'(ACQT_FREE_DIV));
		wr(ACQT_REG_CTRL, 32'h0000_0001);
		for (int g = 2; g < 4; g++)
		begin
			bp.gap = g;
			gap();
			gap();
			chk(32'(n), 32'(ACQT_LOCK_DIV * g));
		end
		wr(ACQT_REG_CTRL, 32'h0000_0100);
		gap();
		gap();
		chk(32'(n), 32'(ACQT_FREE_DIV));
		$display("timebase done");
	endtask

	task t_claim();
		sync();
		for (int m = 0; m < 3; m++)
		begin
			wr(ACQT_REG_ATCFG, 32'(m << 4) | 32'h5);
			rd(ACQT_REG_ATCFG);
			chk(d, 32'(m << 4) | 32'h5);
		end
		wr(ACQT_REG_ATCFG, 32'h0);
		wr(ACQT_REG_LEVEL, 32'h0000_1000);
		wr(ACQT_REG_ENG + ACQT_ENG_CNT, 32'h0003_0002);
		wr(ACQT_REG_ENG, 32'h0001_0223);
		wr(ACQT_REG_ENG + ACQT_ENG_STEP, 32'h0003_0201);
		rd(ACQT_REG_ENG + ACQT_ENG_STEP);
		chk(32'(d[0]), 32'h0);
		rd(ACQT_REG_STAT);
		chk({d[16], 13'h0, d[2:0]}, 17'h10001);
		wr(ACQT_REG_STAT, 32'h0001_0000);
		rd(ACQT_REG_STAT);
		chk(32'(d[16]), 32'h0);
		$display("claim done");
	endtask

	task t_start();
		sync();
		bp.drive_edge(2, 1'b1);
		@(posedge clk);
		adc[0] <= 24'h002000;
		repeat (15) @(posedge clk);
		adc[0] <= 24'h000000;
		wait_st(0, 1);
		repeat (60) @(posedge clk);
		bp.drive_edge(2, 1'b1);
		repeat (6) @(posedge clk);
		wait_st(0, 2);
		repeat (90) @(posedge clk);
		adc[0] <= 24'h002000;
		repeat (10) @(posedge clk);
		adc[0] <= 24'h000000;
		rd(ACQT_REG_STAT);
		chk(32'(d[2:0]), 32'h2);
		$display("start done");
	endtask

	task t_ref();
		wait_st(0, 4);
		chk(32'(trig_cnt), 32'h0);
		@(posedge clk);
		adc[0] <= 24'h002000;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end while (tout == 8'h00 && n < 40);
		chk({toe, tout}, 16'h0101);
		chk(32'(n <= 2 * ACQT_FREE_DIV), 32'h1);
		s0 = stb_cnt;
		wait_st(0, 7);
		chk(32'(stb_cnt - s0), 32'h3);
		chk(32'(trig_cnt), 32'h1);
		$display("reference done");
	endtask

	task t_front();
		wr(ACQT_REG_ENG + ACQT_ENG_STEP, 32'h0002_0385);
		bp.drive_edge(8, 1'b1);
		repeat (6) @(posedge clk);
		wait_st(1, 1);
		bp.drive_edge(8, 1'b0);
		repeat (6) @(posedge clk);
		wait_st(1, 2);
		chk(32'(d[2:0]), 32'h7);
		$display("front done");
	endtask

	// Engine 2 in window mode: a level above the band must not fire, one inside it must.
	task t_window();
		adc[2] <= 24'h004000;
		wr(ACQT_REG_ATCFG, 32'h0000_0022);
		wr(ACQT_REG_BAND, 32'h0000_3000);
		wr(ACQT_REG_ENG + 8'h2 * ACQT_ENG_STEP + ACQT_ENG_CNT, 32'h0001_0001);
		wr(ACQT_REG_ENG + 8'h2 * ACQT_ENG_STEP, 32'h0004_0283);
		bp.drive_edge(8, 1'b1);
		wait_st(2, 4);
		repeat (20) @(posedge clk);
		chk(32'(trig_cnt), 32'h1);
		adc[2] <= 24'h002000;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end while (tout == 8'h00 && n < 40);
		chk({toe, tout}, 16'h0101);
		s0 = stb2_cnt;
		wait_st(2, 7);
		chk(32'(stb2_cnt - s0), 32'h1);
		chk(32'(trig_cnt), 32'h2);
		$display("window done");
	endtask

	task close_out();
		$display("comparisons=%0d failures=%0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial
	begin
		repeat (20000) @(posedge clk);
		failures++;
		close_out();
	end

	initial
	begin
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		t_regs();
		t_tick();
		t_claim();
		t_start();
		t_ref();
		t_front();
		t_window();
		close_out();
	end
endmodule
